// ### hw/srd_shadow_region_decoder.sv
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module srd_shadow_region_decoder
  import srd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [SRD_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic host_valid,
  input wire logic host_write,
  input wire logic [19:0] host_addr,
  output logic route_valid,
  output logic route_dram,
  output logic route_pci,
  output logic route_cacheable,
  input wire logic pwb_threshold_enable,
  input wire logic pwb_over_threshold,
  input wire logic other_latency_out,
  output logic pwb_priority
);
  logic [7:0] read_low;
  logic [7:0] read_high;
  logic [7:0] write_low;
  logic [7:0] write_high;
  logic [7:0] cache_low;
  logic [7:0] cache_high;
  logic [7:0] spare;
  logic [7:0] gated_ctrl;
  logic [7:0] reg_index;
  logic word_aligned;
  logic mapped;
  logic wr_fire;
  logic rd_fire;
  logic in_area;
  logic read_local;
  logic write_local;
  logic seg_cacheable;
  logic next_priority;
  srd_access_t access;

  function automatic logic [7:0] srd_merge(input logic [7:0] old_value,
                                           input logic [31:0] data,
                                           input logic lane_en);
    srd_merge = lane_en ? data[7:0] : old_value;
  endfunction : srd_merge

  // single decode point for every register write strobe
  function automatic logic srd_hit(input logic fire,
                                   input logic [7:0] idx,
                                   input logic [7:0] target);
    srd_hit = fire && (idx == target);
  endfunction : srd_hit

  assign reg_index = paddr[SRD_IDX_MSB:SRD_IDX_LSB];
  assign word_aligned = (paddr[SRD_IDX_LSB-1:0] == '0)
    && (paddr[SRD_ADDR_W-1:SRD_IDX_MSB+1] == '0);
  always_comb
  begin
    case (reg_index)
      SRD_IDX_READ_LOW, SRD_IDX_READ_HIGH, SRD_IDX_WRITE_LOW, SRD_IDX_WRITE_HIGH,
      SRD_IDX_CACHE_LOW, SRD_IDX_CACHE_HIGH, SRD_IDX_SPARE, SRD_IDX_GATED_CTRL,
      SRD_IDX_PWB_STATUS:
        mapped = word_aligned;
      default:
        mapped = 1'b0;
    endcase
  end

  // zero wait states: every access completes in its first access cycle
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign wr_fire = psel & penable & pwrite & mapped;
  assign rd_fire = psel & penable & ~pwrite & mapped;

  // one process per register; every field lives in byte lane 0
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      read_low <= SRD_RESET_VALUE;
    else if (srd_hit(wr_fire, reg_index, SRD_IDX_READ_LOW))
      read_low <= srd_merge(read_low, pwdata, pstrb[0]);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      read_high <= SRD_RESET_VALUE;
    else if (srd_hit(wr_fire, reg_index, SRD_IDX_READ_HIGH))
      read_high <= srd_merge(read_high, pwdata, pstrb[0]);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      write_low <= SRD_RESET_VALUE;
    else if (srd_hit(wr_fire, reg_index, SRD_IDX_WRITE_LOW))
      write_low <= srd_merge(write_low, pwdata, pstrb[0]);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      write_high <= SRD_RESET_VALUE;
    else if (srd_hit(wr_fire, reg_index, SRD_IDX_WRITE_HIGH))
      write_high <= srd_merge(write_high, pwdata, pstrb[0]);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cache_low <= SRD_RESET_VALUE;
    else if (srd_hit(wr_fire, reg_index, SRD_IDX_CACHE_LOW))
      cache_low <= srd_merge(cache_low, pwdata, pstrb[0]);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cache_high <= SRD_RESET_VALUE;
    else if (srd_hit(wr_fire, reg_index, SRD_IDX_CACHE_HIGH))
      cache_high <= srd_merge(cache_high, pwdata, pstrb[0]);
  end

  // spare keeps what software writes but nothing reads it for decoding
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      spare <= SRD_RESET_VALUE;
    else if (srd_hit(wr_fire, reg_index, SRD_IDX_SPARE))
      spare <= srd_merge(spare, pwdata, pstrb[0]);
  end

  // reserved bits 7-5 and 3 stay zero
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      gated_ctrl <= SRD_RESET_VALUE;
    else if (srd_hit(wr_fire, reg_index, SRD_IDX_GATED_CTRL))
      gated_ctrl <= srd_merge(gated_ctrl, pwdata & {24'h0, SRD_GATED_RW_MASK},
                              pstrb[0]);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      prdata <= SRD_ZERO_WORD;
    else if (psel & ~penable & ~pwrite)
    begin
      case (reg_index)
        SRD_IDX_READ_LOW: prdata <= {24'h0, read_low};
        SRD_IDX_READ_HIGH: prdata <= {24'h0, read_high};
        SRD_IDX_WRITE_LOW: prdata <= {24'h0, write_low};
        SRD_IDX_WRITE_HIGH: prdata <= {24'h0, write_high};
        SRD_IDX_CACHE_LOW: prdata <= {24'h0, cache_low};
        SRD_IDX_CACHE_HIGH: prdata <= {24'h0, cache_high};
        SRD_IDX_SPARE: prdata <= {24'h0, spare};
        SRD_IDX_GATED_CTRL: prdata <= {24'h0, gated_ctrl};
        SRD_IDX_PWB_STATUS: prdata <= {29'h0, pwb_priority, other_latency_out,
                                       pwb_over_threshold};
        default: prdata <= SRD_ZERO_WORD;
      endcase
      if (!word_aligned)
        prdata <= SRD_ZERO_WORD;
    end
    else if (rd_fire)
      prdata <= prdata;
  end

  srd_segment_lookup u_lookup
  (
    .mem_addr(host_addr),
    .read_low(read_low),
    .read_high(read_high),
    .write_low(write_low),
    .write_high(write_high),
    .cache_low(cache_low),
    .cache_high(cache_high),
    .in_area(in_area),
    .read_local(read_local),
    .write_local(write_local),
    .cacheable(seg_cacheable)
  );

  srd_pwb_gate u_pwb
  (
    .threshold_enable(pwb_threshold_enable),
    .threshold_mask(gated_ctrl[SRD_MASK_BIT]),
    .over_threshold(pwb_over_threshold),
    .other_latency_out(other_latency_out),
    .pwb_priority(next_priority)
  );

  always_comb
  begin
    case ({host_valid, host_write})
      2'b11: access = SRD_ACC_WRITE;
      2'b10: access = SRD_ACC_READ;
      default: access = SRD_ACC_NONE;
    endcase
  end

  // registered routing: one cycle after the host strobe, decision from current registers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      route_valid <= 1'b0;
      route_dram <= 1'b0;
      route_pci <= 1'b0;
      route_cacheable <= 1'b0;
    end
    else
    begin
      route_valid <= 1'b0;
      route_dram <= 1'b0;
      route_pci <= 1'b0;
      route_cacheable <= 1'b0;
      case (access)
        SRD_ACC_READ:
        begin
          route_valid <= 1'b1;
          route_dram <= in_area & read_local;
          route_pci <= in_area & ~read_local;
          route_cacheable <= seg_cacheable;
        end
        SRD_ACC_WRITE:
        begin
          route_valid <= 1'b1;
          route_dram <= in_area & write_local;
          route_pci <= in_area & ~write_local;
          route_cacheable <= seg_cacheable;
        end
        SRD_ACC_NONE:
          route_valid <= 1'b0;
        default:
          route_valid <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pwb_priority <= 1'b0;
    else
      pwb_priority <= next_priority;
  end
endmodule : srd_shadow_region_decoder

// ### hw/srd_pkg.sv
package srd_pkg;
  localparam int SRD_ADDR_W = 12;
  localparam int SRD_SEG_W = 8;
  // register index sits on byte address bits 9:2
  localparam int SRD_IDX_LSB = 2;
  localparam int SRD_IDX_MSB = 9;
  localparam int SRD_AREA_MSB = 19;
  localparam int SRD_AREA_LSB = 18;
  localparam int SRD_UPPER_BIT = 17;
  localparam int SRD_SEG_MSB = 16;
  localparam int SRD_SEG_LSB = 14;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] SRD_IDX_READ_LOW = 8'h56;
  localparam logic [7:0] SRD_IDX_READ_HIGH = 8'h57;
  localparam logic [7:0] SRD_IDX_WRITE_LOW = 8'h58;
  localparam logic [7:0] SRD_IDX_WRITE_HIGH = 8'h59;
  localparam logic [7:0] SRD_IDX_CACHE_LOW = 8'h5A;
  localparam logic [7:0] SRD_IDX_CACHE_HIGH = 8'h5B;
  localparam logic [7:0] SRD_IDX_SPARE = 8'h5C;
  localparam logic [7:0] SRD_IDX_GATED_CTRL = 8'h5D;
  // status register for the posted write buffer arbitration, index chosen locally
  localparam logic [7:0] SRD_IDX_PWB_STATUS = 8'h70;
  localparam logic [7:0] SRD_RESET_VALUE = 8'h00;
  localparam int SRD_MASK_BIT = 4;
  localparam logic [7:0] SRD_GATED_RW_MASK = 8'h17;
  // legacy area decode on physical address bits 19:14
  localparam logic [1:0] SRD_AREA_TAG = 2'h3;
  localparam int SRD_HI_HALF_BIT = 3;
  localparam int SRD_STATUS_W = 3;
  localparam logic [31:0] SRD_ZERO_WORD = 32'h0000_0000;
  typedef enum logic [2:0]
  {
    SRD_ACC_READ = 3'b001,
    SRD_ACC_WRITE = 3'b010,
    SRD_ACC_NONE = 3'b100
  } srd_access_t;
endpackage : srd_pkg

// ### hw/srd_segment_lookup.sv
`timescale 1ns/1ps
module srd_segment_lookup
  import srd_pkg::*;
(
  input wire logic [19:0] mem_addr,
  input wire logic [SRD_SEG_W-1:0] read_low,
  input wire logic [SRD_SEG_W-1:0] read_high,
  input wire logic [SRD_SEG_W-1:0] write_low,
  input wire logic [SRD_SEG_W-1:0] write_high,
  input wire logic [SRD_SEG_W-1:0] cache_low,
  input wire logic [SRD_SEG_W-1:0] cache_high,
  output logic in_area,
  output logic read_local,
  output logic write_local,
  output logic cacheable
);
  logic [2:0] seg;
  logic upper;

  assign in_area = (mem_addr[SRD_AREA_MSB:SRD_AREA_LSB] == SRD_AREA_TAG);
  assign upper = mem_addr[SRD_UPPER_BIT];
  assign seg = mem_addr[SRD_SEG_MSB:SRD_SEG_LSB];

  // read and write decisions use their own bits so reads may shadow while writes still reach rom; cacheable also needs the read bit
  always_comb
  begin
    read_local = 1'b0;
    write_local = 1'b0;
    cacheable = 1'b0;
    if (in_area)
    begin
      if (upper)
      begin
        read_local = read_high[seg];
        write_local = write_high[seg];
        cacheable = cache_high[seg] & read_high[seg];
      end
      else
      begin
        read_local = read_low[seg];
        write_local = write_low[seg];
        cacheable = cache_low[seg] & read_low[seg];
      end
    end
  end
endmodule : srd_segment_lookup

// ### hw/srd_pwb_gate.sv
`timescale 1ns/1ps
module srd_pwb_gate
(
  input wire logic threshold_enable,
  input wire logic threshold_mask,
  input wire logic over_threshold,
  input wire logic other_latency_out,
  output logic pwb_priority
);
  // the mask only suppresses the over-threshold priority; it never raises it
  assign pwb_priority = threshold_enable & over_threshold
    & ~(threshold_mask & other_latency_out);
endmodule : srd_pwb_gate

// ### verification/srd_host_model.sv
`timescale 1ns/1ps
module srd_host_model
(
  input wire logic clk,
  output logic host_valid,
  output logic host_write,
  output logic [19:0] host_addr
);
  initial
  begin
    host_valid = 1'b0;
    host_write = 1'b0;
    host_addr = 20'h00000;
  end
  // one-cycle host request; the idle address is inverted so a stale value is never reused
  task cycle(input logic wr, input logic [19:0] a);
    @(posedge clk);
    host_valid <= 1'b1;
    host_write <= wr;
    host_addr <= a;
    @(posedge clk);
    host_valid <= 1'b0;
    host_write <= ~wr;
    host_addr <= ~a;
  endtask : cycle
endmodule : srd_host_model

// ### verification/srd_decoder_chk.sv
`timescale 1ns/1ps
module srd_decoder_chk
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  input wire logic host_valid,
  input wire logic host_write,
  input wire logic [19:0] host_addr,
  input wire logic route_valid,
  input wire logic route_dram,
  input wire logic route_pci,
  input wire logic pwb_threshold_enable,
  input wire logic pwb_over_threshold,
  input wire logic other_latency_out,
  input wire logic pwb_priority
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_route_follows: assert property (host_valid |=> route_valid)
    else $error("route result missing after host cycle");
  a_route_cause: assert property (route_valid |-> $past(host_valid))
    else $error("route result without host cycle");
  a_route_onehot: assert property (host_valid && host_addr[19:18] == 2'b11 |=>
    route_dram != route_pci)
    else $error("legacy access not routed to exactly one target");
  a_route_outside: assert property (host_valid && host_addr[19:18] != 2'b11 |=>
    !route_dram && !route_pci)
    else $error("access outside legacy area was routed");
  a_route_quiet: assert property (!route_valid |-> !route_dram && !route_pci)
    else $error("route flags without a result");
  a_pwb_raise: assert property (pwb_threshold_enable && pwb_over_threshold
    && !other_latency_out |=> pwb_priority)
    else $error("over threshold not honoured");
  a_pwb_feature: assert property (!(pwb_threshold_enable && pwb_over_threshold)
    |=> !pwb_priority)
    else $error("priority without enabled over threshold");
  a_bad_addr: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  a_spare_ok: assert property (psel && penable && paddr == 12'h170 |-> !pslverr)
    else $error("spare register refused");
  cover property (host_valid && host_write);
  cover property (route_valid && route_dram);
  cover property (pwb_priority && other_latency_out);
endmodule : srd_decoder_chk
bind srd_shadow_region_decoder srd_decoder_chk u_chk
(
  .clk(clk),
  .sys_rst(sys_rst),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .pslverr(pslverr),
  .host_valid(host_valid),
  .host_write(host_write),
  .host_addr(host_addr),
  .route_valid(route_valid),
  .route_dram(route_dram),
  .route_pci(route_pci),
  .pwb_threshold_enable(pwb_threshold_enable),
  .pwb_over_threshold(pwb_over_threshold),
  .other_latency_out(other_latency_out),
  .pwb_priority(pwb_priority)
);

// ### verification/tb_srd_shadow_region_decoder.sv
`timescale 1ns/1ps
module tb_srd_shadow_region_decoder;
  import srd_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, host_valid, host_write;
  logic [19:0] host_addr;
  logic route_valid, route_dram, route_pci, route_cacheable, pwb_priority;
  logic pwb_threshold_enable = 1'b0;
  logic pwb_over_threshold = 1'b0;
  logic other_latency_out = 1'b0;
  logic [31:0] q;
  logic e, b;
  logic [3:0] x, r;
  logic [1:0] lsb = 2'b00;
  logic [7:0] cfg [6] = '{8'hA5, 8'h3C, 8'h5A, 8'hC3, 8'hFF, 8'h0F};
  int num_errors = 0;
  int n_compared = 0;
  srd_shadow_region_decoder dut
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .host_valid(host_valid),
    .host_write(host_write),
    .host_addr(host_addr),
    .route_valid(route_valid),
    .route_dram(route_dram),
    .route_pci(route_pci),
    .route_cacheable(route_cacheable),
    .pwb_threshold_enable(pwb_threshold_enable),
    .pwb_over_threshold(pwb_over_threshold),
    .other_latency_out(other_latency_out),
    .pwb_priority(pwb_priority)
  );
  srd_host_model host (.clk(clk), .host_valid(host_valid), .host_write(host_write),
    .host_addr(host_addr));
  initial forever #5 clk = ~clk;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, lsb};
    pwdata <= {24'h000000, d};
    pstrb <= 4'hF;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task finish_test();
    $display("comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  initial
  begin
    #20000;
    num_errors++;
    finish_test();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, 8'h56 + 8'(i), 8'h00);
      check(q, SRD_ZERO_WORD);
    end
    apb(1'b1, SRD_IDX_GATED_CTRL, 8'hFF);
    apb(1'b0, SRD_IDX_GATED_CTRL, 8'h00);
    check(q, {24'h000000, SRD_GATED_RW_MASK});
    apb(1'b1, SRD_IDX_SPARE, 8'hA5);
    apb(1'b0, SRD_IDX_SPARE, 8'h00);
    check(q, 32'h0000_00A5);
    apb(1'b1, 8'h80, 8'hFF);
    check(e, 1'b1);
    apb(1'b0, 8'h80, 8'h00);
    check(e, 1'b1);
    check(q, SRD_ZERO_WORD);
    // a misaligned byte address inside a mapped word must still be refused
    lsb = 2'b10;
    apb(1'b0, SRD_IDX_SPARE, 8'h00);
    lsb = 2'b00;
    check(e, 1'b1);
    check(q, SRD_ZERO_WORD);
    for (int i = 0; i < 6; i++) apb(1'b1, 8'h56 + 8'(i), cfg[i]);
    // the top of odd segments probes the 16 KB boundary
    for (int s = 0; s < 16; s++)
      for (int w = 0; w < 2; w++)
      begin
        b = cfg[2 * w + s / 8][s % 8];
        host.cycle(w[0], 20'hC0000 + 20'(s) * 20'h04000 + ((s % 2) ? 20'h03FFF : 20'h00000));
        #1;
        r = {route_valid, route_dram, route_pci, route_cacheable};
        x = {1'b1, b, !b, cfg[4 + s / 8][s % 8] & cfg[s / 8][s % 8]};
        check(r, x);
      end
    host.cycle(1'b0, 20'hBFFFF);
    #1;
    check({route_valid, route_dram, route_pci}, 3'b100);
    // reset in mid-run must clear the routing set up above
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 2; i < 6; i++)
    begin
      apb(1'b0, 8'h56 + 8'(i), 8'h00);
      check(q, SRD_ZERO_WORD);
    end
    host.cycle(1'b1, 20'hFC000);
    #1;
    check({route_valid, route_dram, route_pci, route_cacheable}, 4'b1010);
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, SRD_IDX_GATED_CTRL, 8'(m) << SRD_MASK_BIT);
      for (int c = 0; c < 8; c++)
      begin
        @(posedge clk);
        {pwb_threshold_enable, pwb_over_threshold, other_latency_out} <= 3'(c);
        repeat (2) @(posedge clk);
        #1;
        check(pwb_priority, c[2] & c[1] & ~(m[0] & c[0]));
        apb(1'b0, SRD_IDX_PWB_STATUS, 8'h00);
        check(q, {29'h0, c[2] & c[1] & ~(m[0] & c[0]), c[0], c[1]});
      end
    end
    finish_test();
  end
endmodule : tb_srd_shadow_region_decoder
